// >>> bench/etc_asserts.sv
// Checker for the APB port and interrupt output of etc_top.
// Bound to etc_top; sees its ports only.
`timescale 1ns/1ps
module etc_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc; psel && penable; endsequence
    sequence s_rd; s_acc ##0 !pwrite; endsequence
    property p_rdy; s_acc |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_err; s_acc ##0 (paddr > 12'h014 || paddr[1:0] != 2'b00) |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("no error");
    property p_ok; s_acc ##0 paddr <= 12'h014 && paddr[1:0] == 2'b00 |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("bad error");
    property p_rsv; s_rd ##0 paddr == 0 |-> prdata[1:0] == 0 && prdata[31:16] == 0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits");
    property p_clr; s_rd ##0 paddr == 12'h00c |-> prdata == 0; endproperty
    a_clr: assert property (p_clr) else $error("clear reads");
    property p_one; s_rd ##0 paddr == 12'h014 |-> $onehot(prdata[2:0]); endproperty
    a_one: assert property (p_one) else $error("state");
    property p_hold; s_acc ##1 !psel |-> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("rdata moved");
    property p_mask; s_acc ##0 pwrite && paddr == 12'h010 && pwdata == 0 |=> !irq; endproperty
    a_mask: assert property (p_mask) else $error("irq unmasked");
endmodule // etc_asserts
bind etc_top etc_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// >>> bench/etc_src_model.sv
// Trigger sources: timer, output compare, two edge pins, comparator.
// Bench gives a level pattern; lines follow it one clock later.
`timescale 1ns/1ps
module etc_src_model (
    input  wire logic       pclk,
    input  wire logic [4:0] cmd,
    output logic            timer_trig,
    output logic            output_compare_one,
    output logic            external_edge_pin1,
    output logic            external_edge_pin2,
    output logic            comparator_one_output
);
    // Four edge sources plus comparator, synchronous to pclk
    always @(posedge pclk) begin
        {comparator_one_output, external_edge_pin2, external_edge_pin1,
            output_compare_one, timer_trig} <= cmd;
    end
endmodule // etc_src_model

// >>> bench/test_edge_timing_control.sv
// Bench for etc_top: APB tasks drive registers, source model drives triggers.
// Assumes zero-wait APB slave and sources synchronous to pclk.
`timescale 1ns/1ps
module test_edge_timing_control;
    reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    reg  [11:0] paddr = 0;
    reg  [31:0] pwdata = 0, q, c;
    reg  [4:0]  cmd = 5'h1f;
    reg  [2:0]  k;
    wire [31:0] prdata;
    wire        pready, pslverr, edge_pulse, irq, tt, oc, p1, p2, cp;
    integer     failures = 0, n_compared = 0, cyc = 0, i;
    initial forever #50 pclk = ~pclk;
    etc_src_model u_src (.pclk(pclk), .cmd(cmd), .timer_trig(tt), .output_compare_one(oc),
        .external_edge_pin1(p1), .external_edge_pin2(p2), .comparator_one_output(cp));
    etc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_trig(tt), .output_compare_one(oc), .external_edge_pin1(p1),
        .external_edge_pin2(p2), .comparator_one_output(cp), .edge_pulse(edge_pulse),
        .irq(irq));
    task xf(input w, input [11:0] a, input [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task chk(input [31:0] s, input [31:0] x);
        n_compared = n_compared + 1;
        if (s !== x) begin
            failures = failures + 1;
            $display("[ERR] %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task src(input [4:0] v);
        cmd <= v;
        repeat (4) @(posedge pclk);
    endtask
    task conclude;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures = failures + 1;
            conclude;
        end
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        for (i = 0; i < 6; i = i + 1) begin
            xf(0, 12'(4 * i), 0);
            chk(i == 5 ? q & 32'h7 : q, i == 5 ? 1 : 0);
        end
        xf(0, 12'h018, 0);
        chk(q, 0);
        chk(e, 1);
        $display("test reset and map done");
        xf(1, 12'h004, 1);
        xf(1, 0, 32'hc0c4);
        src(5'h00);
        src(5'h02);
        xf(0, 0, 0);
        chk(q, 32'hc0c4);
        src(5'h03);
        chk(edge_pulse, 1);
        src(5'h01);
        src(5'h03);
        chk(edge_pulse, 0);
        xf(0, 0, 0);
        chk(q, 32'hc3c4);
        xf(0, 12'h008, 0);
        chk(q, 7);
        xf(0, 12'h014, 0);
        chk(q, 32'h1c);
        xf(1, 12'h004, 0);
        xf(1, 12'h00c, 7);
        $display("test sequence done");
        xf(1, 12'h010, 3);
        for (i = 0; i < 6; i = i + 1) begin
            k = (i < 4) ? 3'(i) : 3'(i - 1);
            c = (i < 4) ? 32'hc0d4 | (k << 10) : 32'hd0c0 | (k << 2);
            xf(1, 0, c);
            src(~(5'h01 << k));
            xf(0, 0, 0);
            chk(q, c);
            src(5'h1f);
            xf(0, 0, 0);
            chk(q, c | (i < 4 ? 32'h100 : 32'h200));
            chk(irq, 1);
            src(0);
            xf(1, 0, c);
            xf(1, 12'h00c, 7);
            xf(0, 0, 0);
            chk(q, c);
            chk(irq, 0);
        end
        $display("test source routing done");
        src(1);
        xf(1, 0, 32'h80d4);
        xf(0, 0, 0);
        chk(q, 32'h80d4);
        src(0);
        xf(0, 0, 0);
        chk(q, 32'h81d4);
        xf(1, 12'h010, 0);
        xf(0, 12'h008, 0);
        chk(q, 1);
        chk(irq, 0);
        xf(1, 12'h010, 3);
        src(1);
        xf(1, 0, 32'h40d4);
        xf(1, 0, 32'h40d4);
        xf(0, 0, 0);
        chk(q, 32'h41d4);
        $display("test polarity and level done");
        xf(1, 0, 32'hc0d4);
        xf(1, 0, 32'hc0d4);
        xf(1, 12'h00c, 7);
        xf(0, 0, 0);
        chk(q, 32'hc0d4);
        chk(edge_pulse, 0);
        xf(1, 0, 32'hc1d4);
        xf(0, 0, 0);
        chk(q, 32'hc1d4);
        chk(edge_pulse, 1);
        xf(0, 12'h008, 0);
        chk(q, 0);
        $display("test software flag done");
        conclude;
    end
endmodule // test_edge_timing_control

// >>> hw/etc_edge_chan.v
// One edge channel: source select, polarity and edge or level detection.
// Assumes sources are synchronous to pclk.
`timescale 1ns/1ps
`include "etc_defs.vh"
module etc_edge_chan #(
    parameter CMP_EN = 0
) (
    input  wire       pclk,
    input  wire       presetn,
    input  wire [3:0] sel,
    input  wire       pol,
    input  wire       mode,
    input  wire       src_timer,
    input  wire       src_oc,
    input  wire       src_pin1,
    input  wire       src_pin2,
    input  wire       src_cmp,
    output wire       active,
    output wire       hit
);
    reg  src;
    reg  prev_r;
    wire lvl;
    wire prev_lvl;

    always @* begin
        case (sel)
            `ETC_SRC_TIMER: src = src_timer;
            `ETC_SRC_OCMP:  src = src_oc;
            `ETC_SRC_PIN1:  src = src_pin1;
            `ETC_SRC_PIN2:  src = src_pin2;
            `ETC_SRC_CMP:   src = (CMP_EN != 0) ? src_cmp : 1'b0;
            default:        src = 1'b0;
        endcase
    end

    assign lvl      = pol ? src : ~src;
    // Raw source history, so a polarity rewrite alone is never an edge
    assign prev_lvl = pol ? prev_r : ~prev_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= src;
        end
    end

    assign active = lvl;
    assign hit    = mode ? (lvl & ~prev_lvl) : lvl;
endmodule // etc_edge_chan

// >>> hw/etc_top.v
// Edge timing control: APB registers, two edge channels, pulse and interrupt.
// Assumes trigger sources synchronous to pclk; APB master per AMBA APB.
`timescale 1ns/1ps
`include "etc_defs.vh"
module etc_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        timer_trig,
    input  wire        output_compare_one,
    input  wire        external_edge_pin1,
    input  wire        external_edge_pin2,
    input  wire        comparator_one_output,
    output wire        edge_pulse,
    output wire        irq
);
    localparam ST_IDLE = 3'b001;
    localparam ST_RUN  = 3'b010;
    localparam ST_DONE = 3'b100;

    reg  [15:0] ctrl_r;
    reg  [15:0] ctrl_nxt;
    reg         seq_en_r;
    reg  [2:0]  int_stat_r;
    reg  [2:0]  int_en_r;
    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg  [31:0] prdata_r;
    reg         pulse_r;
    reg         pulse_nxt;
    wire        wr;
    wire        rd;
    wire        addr_ok;
    wire        e1_hit;
    wire        e2_hit;
    wire        e1_act;
    wire        e2_act;
    wire        e1_ok;
    wire        e2_ok;
    wire        e1_flag;
    wire        e2_flag;
    wire [2:0]  ev;

    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    assign addr_ok = (paddr == `ETC_OFF_CTRL) | (paddr == `ETC_OFF_SEQ) |
                     (paddr == `ETC_OFF_INT_STAT) | (paddr == `ETC_OFF_INT_CLR) |
                     (paddr == `ETC_OFF_INT_EN) | (paddr == `ETC_OFF_STATE);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata  = prdata_r;

    etc_edge_chan #(
        .CMP_EN    (0)
    ) u_chan1 (
        .pclk      (pclk),
        .presetn   (presetn),
        .sel       (ctrl_r[`ETC_E1_SEL_HI:`ETC_E1_SEL_LO]),
        .pol       (ctrl_r[`ETC_E1_POL_BIT]),
        .mode      (ctrl_r[`ETC_E1_MODE_BIT]),
        .src_timer (timer_trig),
        .src_oc    (output_compare_one),
        .src_pin1  (external_edge_pin1),
        .src_pin2  (external_edge_pin2),
        .src_cmp   (comparator_one_output),
        .active    (e1_act),
        .hit       (e1_hit)
    );

    etc_edge_chan #(
        .CMP_EN    (1)
    ) u_chan2 (
        .pclk      (pclk),
        .presetn   (presetn),
        .sel       (ctrl_r[`ETC_E2_SEL_HI:`ETC_E2_SEL_LO]),
        .pol       (ctrl_r[`ETC_E2_POL_BIT]),
        .mode      (ctrl_r[`ETC_E2_MODE_BIT]),
        .src_timer (timer_trig),
        .src_oc    (output_compare_one),
        .src_pin1  (external_edge_pin1),
        .src_pin2  (external_edge_pin2),
        .src_cmp   (comparator_one_output),
        .active    (e2_act),
        .hit       (e2_hit)
    );

    assign e1_flag = ctrl_r[`ETC_E1_FLAG_BIT];
    assign e2_flag = ctrl_r[`ETC_E2_FLAG_BIT];
    // Second edge waits for the first when ordering is on
    assign e1_ok = e1_hit;
    assign e2_ok = e2_hit & (~seq_en_r | e1_flag);

    // Flags: hardware set wins over a software clear in the same cycle
    always @* begin
        ctrl_nxt = ctrl_r;
        if (wr && paddr == `ETC_OFF_CTRL) begin
            ctrl_nxt = pwdata[15:0] & `ETC_CTRL_MASK;
        end
        if (e1_ok) begin
            ctrl_nxt[`ETC_E1_FLAG_BIT] = 1'b1;
        end
        if (e2_ok) begin
            ctrl_nxt[`ETC_E2_FLAG_BIT] = 1'b1;
        end
    end

    // Pulse spans from first edge flag to second edge flag
    always @* begin
        state_nxt = state_r;
        pulse_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (ctrl_nxt[`ETC_E1_FLAG_BIT] && !ctrl_nxt[`ETC_E2_FLAG_BIT]) begin
                    state_nxt = ST_RUN;
                    pulse_nxt = 1'b1;
                end
            end
            ST_RUN: begin
                pulse_nxt = 1'b1;
                if (ctrl_nxt[`ETC_E2_FLAG_BIT]) begin
                    state_nxt = ST_DONE;
                    pulse_nxt = 1'b0;
                end else if (!ctrl_nxt[`ETC_E1_FLAG_BIT]) begin
                    state_nxt = ST_IDLE;
                    pulse_nxt = 1'b0;
                end
            end
            ST_DONE: begin
                if (!ctrl_nxt[`ETC_E1_FLAG_BIT] && !ctrl_nxt[`ETC_E2_FLAG_BIT]) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    assign ev = {(state_r == ST_RUN) & (state_nxt == ST_DONE), e2_ok, e1_ok};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= `ETC_CTRL_RESET;
            seq_en_r   <= 1'b0;
            int_stat_r <= 3'h0;
            int_en_r   <= 3'h0;
            state_r    <= ST_IDLE;
            pulse_r    <= 1'b0;
            prdata_r   <= 32'h0000_0000;
        end else begin
            ctrl_r   <= ctrl_nxt;
            state_r  <= state_nxt;
            pulse_r  <= pulse_nxt;
            if (wr && paddr == `ETC_OFF_SEQ) begin
                seq_en_r <= pwdata[0];
            end
            if (wr && paddr == `ETC_OFF_INT_EN) begin
                int_en_r <= pwdata[2:0];
            end
            if (wr && paddr == `ETC_OFF_INT_CLR) begin
                int_stat_r <= (int_stat_r & ~pwdata[2:0]) | ev;
            end else begin
                int_stat_r <= int_stat_r | ev;
            end
            if (rd) begin
                case (paddr)
                    `ETC_OFF_CTRL:     prdata_r <= {16'h0000, ctrl_r};
                    `ETC_OFF_SEQ:      prdata_r <= {31'h0, seq_en_r};
                    `ETC_OFF_INT_STAT: prdata_r <= {29'h0, int_stat_r};
                    `ETC_OFF_INT_EN:   prdata_r <= {29'h0, int_en_r};
                    `ETC_OFF_STATE:    prdata_r <= {27'h0, e2_act, e1_act, state_r};
                    default:           prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign edge_pulse = pulse_r;
    assign irq = |(int_stat_r & int_en_r);
endmodule // etc_top

// >>> include/etc_defs.vh
// Constants of the edge timing control block: register map, fields, codes.
// Assumes a 32-bit APB slave with byte addresses and word-aligned registers.
`ifndef ETC_DEFS_VH
`define ETC_DEFS_VH

`define ETC_OFF_CTRL        12'h000
`define ETC_OFF_SEQ         12'h004
`define ETC_OFF_INT_STAT    12'h008
`define ETC_OFF_INT_CLR     12'h00c
`define ETC_OFF_INT_EN      12'h010
`define ETC_OFF_STATE       12'h014

`define ETC_CTRL_RESET      16'h0000
`define ETC_CTRL_MASK       16'hfffc
`define ETC_E1_MODE_BIT     15
`define ETC_E1_POL_BIT      14
`define ETC_E1_SEL_HI       13
`define ETC_E1_SEL_LO       10
`define ETC_E2_FLAG_BIT     9
`define ETC_E1_FLAG_BIT     8
`define ETC_E2_MODE_BIT     7
`define ETC_E2_POL_BIT      6
`define ETC_E2_SEL_HI       5
`define ETC_E2_SEL_LO       2

`define ETC_SRC_TIMER       4'h0
`define ETC_SRC_OCMP        4'h1
`define ETC_SRC_PIN1        4'h2
`define ETC_SRC_PIN2        4'h3
`define ETC_SRC_CMP         4'h4

`define ETC_INT_E1          0
`define ETC_INT_E2          1
`define ETC_INT_DONE        2

`endif
